/* File: design/hss_regs.sv */
`timescale 1ns/1ns
module hss_regs
   import hss_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic restart_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   input wire hss_srcs_t srcs_i,
   input wire hss_events_t events_i,
   input wire logic irq_pending_i,
   input wire logic dev_mode_i,
   output logic [3:0] switch_on_o,
   output logic irq_out_n_o,
   output logic devmode_watchdog_off_o
);

   hss_state_t st;
   hss_state_t next_st;
   logic [3:0] mux_on;
   logic [6:0] ev_en;
   logic ev_hit;
   logic period_hit;

   // ************************************************************
   // Switch source decode, one mux per switch
   // ************************************************************
   genvar g;
   for (g = 0; g < HSS_NUM_SW; g++) begin : g_sw
      hss_src_mux u_mux (
         .code_i(st.src_sel[g*HSS_SRC_W +: HSS_SRC_W]),
         .srcs_i(srcs_i),
         .on_o(mux_on[g])
      );
   end

   // ************************************************************
   // Event gating
   // ************************************************************
   // Each event is gated by its own mask bit; frame and checksum share one.
   assign ev_en[0] = events_i.supply_summary & st.mask[HSS_BIT_SUPPLY];
   assign ev_en[1] = events_i.temp_summary & st.mask[HSS_BIT_TEMP];
   assign ev_en[2] = events_i.bus_summary & st.mask[HSS_BIT_BUS];
   assign ev_en[3] = events_i.switch_summary & st.mask[HSS_BIT_SWITCH];
   assign ev_en[4] = events_i.bridge_driver_summary & st.mask[HSS_BIT_BRIDGE];
   assign ev_en[5] = (events_i.frame_fail | events_i.crc_fail) & st.mask[HSS_BIT_SER_FAIL];
   assign ev_en[6] = events_i.wd_fail_devmode & st.mask[HSS_BIT_WD_FAIL];
   // No memory of earlier status: an event already set still fires.
   assign ev_hit = |ev_en;
   assign period_hit = st.mask[HSS_BIT_PERIODIC] & irq_pending_i & (st.period_cnt == HSS_CNT_ONE);

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      next_st = st;
      next_st.sw_on = mux_on;
      if (restart_i) begin
         next_st.src_sel = HSS_SRC_SEL_RESET;
      end else if (reg_wr_i && reg_addr_i == HSS_ADDR_SRC_SEL) begin
         next_st.src_sel = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == HSS_ADDR_IRQ_MASK) begin
         next_st.mask = reg_wdata_i[HSS_MASK_W-1:0];
      end
      // Read data is captured so the answer comes from a flip-flop.
      if (reg_rd_i) begin
         if (reg_addr_i == HSS_ADDR_SRC_SEL) begin
            next_st.rdata = st.src_sel;
         end else if (reg_addr_i == HSS_ADDR_IRQ_MASK) begin
            next_st.rdata = {7'h00, st.mask};
         end else begin
            next_st.rdata = 16'h0000;
         end
      end
      // The repeat timer runs only while something is pending and enabled.
      if (!(st.mask[HSS_BIT_PERIODIC] && irq_pending_i) || period_hit) begin
         next_st.period_cnt = HSS_PERIOD_CYC;
      end else begin
         next_st.period_cnt = st.period_cnt - HSS_CNT_ONE;
      end
      unique case (st.irq_st)
         HSS_IRQ_IDLE: begin
            if (ev_hit || period_hit || st.again) begin
               next_st.irq_st = HSS_IRQ_PULSE;
               next_st.pulse_cnt = HSS_PULSE_CYC;
               next_st.again = 1'b0;
            end
         end
         HSS_IRQ_PULSE: begin
            // Events during a pulse are remembered in one flag and share one further pulse.
            if (ev_hit || period_hit) begin
               next_st.again = 1'b1;
            end
            if (st.pulse_cnt == HSS_CNT_ONE) begin
               next_st.irq_st = HSS_IRQ_IDLE;
               next_st.pulse_cnt = HSS_CNT_ZERO;
            end else begin
               next_st.pulse_cnt = st.pulse_cnt - HSS_CNT_ONE;
            end
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Clock enable low holds every field, counters and the interrupt pulse included.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
         st.src_sel <= HSS_SRC_SEL_RESET;
         st.mask <= HSS_MASK_RESET;
         st.irq_st <= HSS_IRQ_IDLE;
         st.period_cnt <= HSS_PERIOD_CYC;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // Outputs other than devmode_watchdog_off_o come straight from the state flops, so they never glitch.
   assign switch_on_o = st.sw_on;
   assign reg_rdata_o = st.rdata;
   assign irq_out_n_o = (st.irq_st != HSS_IRQ_PULSE);
   // Gated here with dev_mode_i, so the watchdog-off request is raised only while in development mode.
   assign devmode_watchdog_off_o = st.mask[HSS_BIT_WD_OFF] & dev_mode_i;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_ev_taken;
      ce_i && ev_hit && st.irq_st == HSS_IRQ_IDLE;
   endsequence

   sequence s_pulse_low;
      !irq_out_n_o;
   endsequence

   a_event_pulses: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_ev_taken |=> s_pulse_low)
      else $error("Enabled event did not pull the interrupt low.");

   a_masked_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && st.irq_st == HSS_IRQ_IDLE && !st.again && events_i.wd_fail_devmode
       && !st.mask[HSS_BIT_WD_FAIL] && ev_en == 7'h00 && !period_hit) |=> irq_out_n_o)
      else $error("Masked event pulled the interrupt low.");

   a_reserved_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && reg_rd_i && reg_addr_i == HSS_ADDR_IRQ_MASK) |=> reg_rdata_o[15:9] == 7'h00)
      else $error("Reserved mask bits read nonzero.");

   a_src_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && reg_wr_i && !restart_i && reg_addr_i == HSS_ADDR_SRC_SEL) |=> st.src_sel == $past(reg_wdata_i))
      else $error("Source select write not stored.");

   a_restart_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && restart_i) |=> st.src_sel == HSS_SRC_SEL_RESET)
      else $error("Restart did not clear the source select.");

   a_code_on: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && st.src_sel[3:0] == HSS_SRC_ON) |=> switch_on_o[0])
      else $error("Switch one not on one cycle after code on.");

   a_reserved_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && st.src_sel[15:12] > HSS_SRC_WAKE_SYNC) |=> !switch_on_o[3])
      else $error("Switch four driven under a reserved code.");

   a_pwm_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && st.src_sel[7:4] == HSS_SRC_PWM_C) |=> switch_on_o[1] == $past(srcs_i.pwm_gen[2]))
      else $error("Switch two does not follow generator three.");

   a_pulse_width: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && st.irq_st == HSS_IRQ_PULSE && st.pulse_cnt == HSS_CNT_ONE) |=> irq_out_n_o || !ce_i)
      else $error("Interrupt pulse overran its width.");

   a_wd_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!dev_mode_i |-> !devmode_watchdog_off_o))
      else $error("Watchdog disabled outside development mode.");

   // The last cycle of a pulse that has a further event waiting behind it.
   sequence s_pulse_end;
      ce_i && st.irq_st == HSS_IRQ_PULSE && st.pulse_cnt == HSS_CNT_ONE && st.again;
   endsequence

   a_again_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_pulse_end ##1 ce_i |=> s_pulse_low)
      else $error("Event seen during a pulse got no pulse of its own.");

   a_periodic_fire: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && period_hit && st.irq_st == HSS_IRQ_IDLE) |=> s_pulse_low)
      else $error("Periodic expiry did not pull the interrupt low.");

   a_no_periodic: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && !st.mask[HSS_BIT_PERIODIC]) |=> st.period_cnt == HSS_PERIOD_CYC)
      else $error("Repeat timer ran with periodic interrupts disabled.");

   a_timer_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && st.src_sel[11:8] == HSS_SRC_TIMER_B) |=> switch_on_o[2] == $past(srcs_i.timer_b))
      else $error("Switch three does not follow the second timer.");

   a_wake_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (ce_i && st.src_sel[3:0] == HSS_SRC_WAKE_SYNC)
      |=> switch_on_o[0] == ($past(srcs_i.wake_sync) & $past(srcs_i.wake_sync_role)))
      else $error("Switch one does not follow the wake sync input.");

   a_freeze_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !ce_i |=> $stable(st))
      else $error("State changed while the clock enable was low.");

endmodule : hss_regs

/* File: design/hss_pkg.sv */
package hss_pkg;

   // ************************************************************
   // Register map and field layout
   // ************************************************************
   localparam logic [6:0] HSS_ADDR_SRC_SEL = 7'h08;
   localparam logic [6:0] HSS_ADDR_IRQ_MASK = 7'h09;
   localparam logic [15:0] HSS_SRC_SEL_RESET = 16'h0000;
   localparam logic [8:0] HSS_MASK_RESET = 9'h140;
   localparam int HSS_SRC_W = 4;
   localparam int HSS_NUM_SW = 4;
   localparam int HSS_MASK_W = 9;
   localparam int HSS_BIT_PERIODIC = 8;
   localparam int HSS_BIT_WD_OFF = 7;
   localparam int HSS_BIT_WD_FAIL = 6;
   localparam int HSS_BIT_SER_FAIL = 5;
   localparam int HSS_BIT_BRIDGE = 4;
   localparam int HSS_BIT_SWITCH = 3;
   localparam int HSS_BIT_BUS = 2;
   localparam int HSS_BIT_TEMP = 1;
   localparam int HSS_BIT_SUPPLY = 0;

   // ************************************************************
   // Source-select codes
   // ************************************************************
   localparam logic [3:0] HSS_SRC_OFF = 4'h0;
   localparam logic [3:0] HSS_SRC_ON = 4'h1;
   localparam logic [3:0] HSS_SRC_TIMER_A = 4'h2;
   localparam logic [3:0] HSS_SRC_TIMER_B = 4'h3;
   localparam logic [3:0] HSS_SRC_PWM_A = 4'h4;
   localparam logic [3:0] HSS_SRC_PWM_B = 4'h5;
   localparam logic [3:0] HSS_SRC_PWM_C = 4'h6;
   localparam logic [3:0] HSS_SRC_PWM_D = 4'h7;
   localparam logic [3:0] HSS_SRC_WAKE_SYNC = 4'h8;

   // ************************************************************
   // Interrupt output timing
   // ************************************************************
   localparam int HSS_CLK_PERIOD_NS = 4;
   localparam int HSS_IRQ_PULSE_NS = 1000;
   localparam int HSS_IRQ_PERIOD_NS = 10000;
   localparam logic [11:0] HSS_PULSE_CYC = 12'(HSS_IRQ_PULSE_NS / HSS_CLK_PERIOD_NS);
   localparam logic [11:0] HSS_PERIOD_CYC = 12'(HSS_IRQ_PERIOD_NS / HSS_CLK_PERIOD_NS);
   localparam logic [11:0] HSS_CNT_ONE = 12'h001;
   localparam logic [11:0] HSS_CNT_ZERO = 12'h000;

   typedef enum logic [0:0] {HSS_IRQ_IDLE, HSS_IRQ_PULSE} hss_irq_st_t;

   // Switch drive sources as they arrive from the timers and generators.
   typedef struct packed {
      logic timer_a;
      logic timer_b;
      logic [3:0] pwm_gen;
      logic wake_sync;
      logic wake_sync_role;
   } hss_srcs_t;

   // Status events, one-cycle pulses from the status logic.
   typedef struct packed {
      logic wd_fail_devmode;
      logic frame_fail;
      logic crc_fail;
      logic bridge_driver_summary;
      logic switch_summary;
      logic bus_summary;
      logic temp_summary;
      logic supply_summary;
   } hss_events_t;

   typedef struct packed {
      logic [15:0] src_sel;
      logic [8:0] mask;
      logic [3:0] sw_on;
      hss_irq_st_t irq_st;
      logic [11:0] pulse_cnt;
      logic [11:0] period_cnt;
      logic again;
      logic [15:0] rdata;
   } hss_state_t;

endpackage : hss_pkg

/* File: design/hss_src_mux.sv */
`timescale 1ns/1ns
// Picks the drive level of one switch from its 4-bit source code.
module hss_src_mux
   import hss_pkg::*;
(
   input wire logic [3:0] code_i,
   input wire hss_srcs_t srcs_i,
   output logic on_o
);

   // ************************************************************
   // Source decode
   // ************************************************************
   // Reserved codes fall to the default and keep the switch off.
   always_comb begin
      unique case (code_i)
         HSS_SRC_OFF: on_o = 1'b0;
         HSS_SRC_ON: on_o = 1'b1;
         HSS_SRC_TIMER_A: on_o = srcs_i.timer_a;
         HSS_SRC_TIMER_B: on_o = srcs_i.timer_b;
         HSS_SRC_PWM_A: on_o = srcs_i.pwm_gen[0];
         HSS_SRC_PWM_B: on_o = srcs_i.pwm_gen[1];
         HSS_SRC_PWM_C: on_o = srcs_i.pwm_gen[2];
         HSS_SRC_PWM_D: on_o = srcs_i.pwm_gen[3];
         HSS_SRC_WAKE_SYNC: on_o = srcs_i.wake_sync & srcs_i.wake_sync_role;
         default: on_o = 1'b0;
      endcase
   end

endmodule : hss_src_mux

/* File: verification/hss_host.sv */
`timescale 1ns/1ns
// ************************************************************
// Host model on the register port
// ************************************************************
module hss_host (
   input wire logic clk_i,
   input wire logic [15:0] rdata_i,
   input wire logic irq_n_i,
   output logic [6:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [15:0] wdata_o
);
   int irq_cnt = 0;
   initial begin
      addr_o = 7'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 16'h0000;
   end
   // Falling edges of the active-low interrupt are counted as pulses.
   always @(negedge irq_n_i) irq_cnt++;
   // Reserved codes are sent only when a scenario probes them on purpose.
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d; // Released data must not look like the last word.
   endtask : wr
   // Read data is taken 1 ns after the edge that samples the strobe.
   task automatic rd(input logic [6:0] a, output logic [15:0] q);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 q = rdata_i;
   endtask : rd
endmodule : hss_host

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %0t: got %h want %h", $time, (g), (e)); end end
module testbench;
   import hss_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic restart_i = 1'b0;
   logic irq_pending_i = 1'b0;
   logic dev_mode_i = 1'b0;
   logic ce = 1'b1;
   hss_srcs_t srcs = '0;
   hss_events_t events = '0;
   logic [6:0] addr;
   logic wr;
   logic rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] q;
   logic [3:0] sw;
   logic irq_n;
   logic wdoff;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n0;
   // ************************************************************
   // Clock, design and host
   // ************************************************************
   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   hss_regs dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce), .restart_i(restart_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .srcs_i(srcs), .events_i(events), .irq_pending_i(irq_pending_i), .dev_mode_i(dev_mode_i),
      .switch_on_o(sw), .irq_out_n_o(irq_n), .devmode_watchdog_off_o(wdoff));
   hss_host host (.clk_i(sys_clk_i), .rdata_i(rdata), .irq_n_i(irq_n), .addr_o(addr), .wr_o(wr),
      .rd_o(rd), .wdata_o(wdata));
   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   // A hang is cut short well beyond the expected length of the run.
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   // Expected drive of a switch, worked out from the code table.
   function automatic logic exp_on(logic [3:0] c, hss_srcs_t s);
      case (c)
         4'h1: return 1'b1;
         4'h2: return s.timer_a;
         4'h3: return s.timer_b;
         4'h4, 4'h5, 4'h6, 4'h7: return s.pwm_gen[c[1:0]];
         4'h8: return s.wake_sync & s.wake_sync_role;
         default: return 1'b0;
      endcase
   endfunction : exp_on
   task automatic t_codes;
      logic [3:0] c;
      for (int p = 0; p < 2; p++) begin
         @(posedge sys_clk_i) srcs <= hss_srcs_t'(p == 0 ? 8'ha7 : 8'h58);
         for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            host.wr(HSS_ADDR_SRC_SEL, {4{c}});
            @(posedge sys_clk_i) #1;
            `CHK(sw, {4{exp_on(c, srcs)}})
         end
      end
      host.wr(HSS_ADDR_SRC_SEL, 16'h0110);
      @(posedge sys_clk_i) #1;
      `CHK(sw, 4'b0110)
      // Wake input high but not in its sync role must leave code 8 off.
      @(posedge sys_clk_i) srcs <= hss_srcs_t'(8'h02);
      host.wr(HSS_ADDR_SRC_SEL, 16'h8888);
      @(posedge sys_clk_i) #1;
      `CHK(sw, 4'h0)
      $display("Source codes done");
   endtask : t_codes
   // A write made while the clock enable is low must not land.
   task automatic t_freeze;
      host.wr(HSS_ADDR_SRC_SEL, 16'h0001);
      @(posedge sys_clk_i) ce <= 1'b0;
      host.wr(HSS_ADDR_SRC_SEL, 16'h1000);
      @(posedge sys_clk_i) #1;
      `CHK(sw, 4'h1)
      @(posedge sys_clk_i) ce <= 1'b1;
      host.rd(HSS_ADDR_SRC_SEL, q);
      `CHK(q, 16'h0001)
      $display("Clock enable done");
   endtask : t_freeze
   task automatic t_mask;
      host.wr(HSS_ADDR_IRQ_MASK, 16'hffff);
      host.rd(HSS_ADDR_IRQ_MASK, q);
      `CHK(q, 16'h01ff)
      host.rd(7'h0a, q);
      `CHK(q, 16'h0000)
      `CHK(wdoff, 1'b0)
      @(posedge sys_clk_i) dev_mode_i <= 1'b1;
      #1 `CHK(wdoff, 1'b1)
      host.wr(HSS_ADDR_IRQ_MASK, 16'h0000);
      #1 `CHK(wdoff, 1'b0)
      $display("Mask register done");
   endtask : t_mask
   // Pulses one event; when it is enabled the full pulse shape is checked.
   task automatic pulse_ev(int i, logic en);
      n0 = host.irq_cnt;
      @(posedge sys_clk_i) events <= hss_events_t'(8'h01 << i);
      @(posedge sys_clk_i) events <= '0;
      #1 `CHK(irq_n, !en)
      repeat (249) @(posedge sys_clk_i);
      #1 `CHK(irq_n, !en)
      @(posedge sys_clk_i) #1;
      `CHK(irq_n, 1'b1)
      `CHK(host.irq_cnt - n0, int'(en))
   endtask : pulse_ev
   task automatic t_events;
      int mb;
      for (int i = 0; i < 8; i++) begin
         mb = (i < 5) ? i : ((i == 7) ? 6 : 5);
         host.wr(HSS_ADDR_IRQ_MASK, 16'h007f & ~(16'h0001 << mb));
         pulse_ev(i, 1'b0);
         host.wr(HSS_ADDR_IRQ_MASK, 16'h0001 << mb);
         pulse_ev(i, 1'b1);
      end
      // Two events inside a running pulse merge into one more pulse.
      n0 = host.irq_cnt;
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk_i) events <= hss_events_t'(8'h80);
         repeat (40) @(posedge sys_clk_i) events <= '0;
      end
      repeat (600) @(posedge sys_clk_i);
      `CHK(host.irq_cnt - n0, 2)
      $display("Interrupt events done");
   endtask : t_events
   task automatic t_periodic;
      @(posedge sys_clk_i) irq_pending_i <= 1'b1;
      n0 = host.irq_cnt;
      repeat (2600) @(posedge sys_clk_i);
      `CHK(host.irq_cnt - n0, 0)
      host.wr(HSS_ADDR_IRQ_MASK, 16'h0100);
      n0 = host.irq_cnt;
      repeat (5100) @(posedge sys_clk_i);
      `CHK(host.irq_cnt - n0, 2)
      @(posedge sys_clk_i) irq_pending_i <= 1'b0;
      $display("Periodic interrupt done");
   endtask : t_periodic
   task automatic t_restart;
      host.wr(HSS_ADDR_SRC_SEL, 16'h1111);
      host.wr(HSS_ADDR_IRQ_MASK, 16'h0055);
      @(posedge sys_clk_i) restart_i <= 1'b1;
      @(posedge sys_clk_i) restart_i <= 1'b0;
      host.rd(HSS_ADDR_SRC_SEL, q);
      `CHK(q, 16'h0000)
      `CHK(sw, 4'h0)
      host.rd(HSS_ADDR_IRQ_MASK, q);
      `CHK(q, 16'h0055)
      $display("Restart done");
   endtask : t_restart
   initial begin
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      host.rd(HSS_ADDR_SRC_SEL, q);
      `CHK(q, 16'h0000)
      host.rd(HSS_ADDR_IRQ_MASK, q);
      `CHK(q, 16'h0140)
      `CHK(irq_n, 1'b1)
      $display("Reset values done");
      t_codes();
      t_freeze();
      t_mask();
      t_events();
      t_periodic();
      t_restart();
      tally_and_finish();
   end
endmodule : testbench
